// >>> ssd_host_pkg.sv
// constants shared by the ssd test command host controller
package ssd_host_pkg;
  localparam int DATA_W     = 32;
  localparam int OWN_AW     = 8;
  localparam int DEV_AW     = 16;
  localparam int SQE_WORDS  = 16;
  localparam int SQE_IDX_W  = 4;
  localparam int LBA_W      = 48;
  // device register map (byte addresses)
  localparam logic [15:0] DEV_USR_CMD    = 16'h0100;
  localparam logic [15:0] DEV_USR_STS    = 16'h0104;
  localparam logic [15:0] DEV_ERR_TYPE   = 16'h0108;
  localparam logic [15:0] DEV_LINK_STS   = 16'h010c;
  localparam logic [15:0] DEV_PATT_SEL   = 16'h0110;
  localparam logic [15:0] DEV_ADR_L      = 16'h0114;
  localparam logic [15:0] DEV_ADR_H      = 16'h0118;
  localparam logic [15:0] DEV_FIFO_SPACE = 16'h0124;
  localparam logic [15:0] DEV_SLOW_FLAG  = 16'h0128;
  localparam logic [15:0] DEV_CAP_L      = 16'h0130;
  localparam logic [15:0] DEV_CAP_H      = 16'h0134;
  localparam logic [15:0] DEV_CNT_L      = 16'h0148;
  localparam logic [15:0] DEV_CNT_H      = 16'h014c;
  localparam logic [15:0] DEV_SQE_BASE   = 16'h0200;
  // device status bits
  localparam int STS_BUSY   = 0;
  localparam int STS_ERR    = 1;
  localparam int STS_VERIFY = 2;
  localparam int LINK_UP    = 0;
  // command codes
  localparam logic [2:0] CMD_IDENTIFY = 3'h0;
  localparam logic [2:0] CMD_SHUTDOWN = 3'h1;
  localparam logic [2:0] CMD_WRITE    = 3'h2;
  localparam logic [2:0] CMD_READ     = 3'h3;
  localparam logic [2:0] CMD_SMART    = 3'h4;
  localparam logic [2:0] CMD_FLUSH    = 3'h6;
  // own register map (byte addresses)
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_PATT     = 8'h04;
  localparam logic [7:0] REG_START_L  = 8'h08;
  localparam logic [7:0] REG_START_H  = 8'h0c;
  localparam logic [7:0] REG_LEN      = 8'h10;
  localparam logic [7:0] REG_POLY     = 8'h14;
  localparam logic [7:0] REG_STATUS   = 8'h18;
  localparam logic [7:0] REG_ERRTYPE  = 8'h1c;
  localparam logic [7:0] REG_LINK     = 8'h20;
  localparam logic [7:0] REG_CAP_L    = 8'h24;
  localparam logic [7:0] REG_CAP_H    = 8'h28;
  localparam logic [7:0] REG_CNT_L    = 8'h2c;
  localparam logic [7:0] REG_CNT_H    = 8'h30;
  localparam logic [7:0] REG_SQE_BASE = 8'h40;
  // own status bit positions
  localparam int ST_BIT_BUSY   = 0;
  localparam int ST_BIT_READY  = 1;
  localparam int ST_BIT_ERR    = 2;
  localparam int ST_BIT_VERIFY = 3;
  localparam int ST_BIT_SLOW   = 4;
  localparam int ST_BIT_DEAD   = 5;
  localparam int ST_BIT_REJECT = 6;
  // sectors in one 4 kbyte block, and alignment mask
  localparam logic [47:0] BLOCK_SECTORS = 48'h8;
  localparam logic [2:0]  ALIGN_MASK    = 3'h7;
  localparam logic [31:0] POLY_RESET    = 32'h80200003;
endpackage

// >>> sqe_if.sv
// carrier between controller and submission entry memory
`timescale 1ns/100ps
interface sqe_if;
  import ssd_host_pkg::*;
  logic                 wr_en;
  logic [SQE_IDX_W-1:0] wr_idx;
  logic [DATA_W-1:0]    wr_data;
  logic [SQE_IDX_W-1:0] rd_idx;
  logic [DATA_W-1:0]    rd_data;
  modport owner (output wr_en, wr_idx, wr_data, rd_idx, input rd_data);
  modport mem   (input wr_en, wr_idx, wr_data, rd_idx, output rd_data);
endinterface

// >>> ssd_sqe_mem.sv
// sixteen-word store for the custom submission entry
`timescale 1ns/100ps
module ssd_sqe_mem #(
  parameter int WORDS = 16
) (
  input  wire logic clk_sys_in, // system clock
  sqe_if.mem        port_in     // write and registered read port
);
  logic [31:0] mem_q [WORDS];

  always_ff @(posedge clk_sys_in) begin
    if (port_in.wr_en) begin
      mem_q[port_in.wr_idx] <= port_in.wr_data;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    port_in.rd_data <= mem_q[port_in.rd_idx];
  end
endmodule

// >>> ssd_cmd_host.sv
// host controller driving the ssd test command register port over apb
// Functional notes
// - poll link status bit 0 until set
// - wait init busy clear, stop on error
// - start and length multiples of 8 sectors
// - program pattern select before write/read command code
// - push at most min(fifo space, remaining)
// - push addresses via low/high registers
// - sequential addresses advance one 4k block
// - random addresses by lfsr within capacity
// - after queuing wait busy clear, check errors
// - load sixteen entry words before smart/flush command
`timescale 1ns/100ps
module ssd_cmd_host (
  input  wire logic                      clk_sys_in,     // system clock
  input  wire logic                      rst_n_in,       // sync reset
  input  wire logic                      s_psel_in,      // own apb select
  input  wire logic                      s_penable_in,   // own apb enable
  input  wire logic                      s_pwrite_in,    // own apb direction
  input  wire logic [ssd_host_pkg::OWN_AW-1:0] s_paddr_in, // own apb address
  input  wire logic [31:0]               s_pwdata_in,    // own apb write data
  output logic      [31:0]               s_prdata_out,   // own apb read data
  output logic                           s_pready_out,   // own apb ready
  output logic                           s_pslverr_out,  // own apb error
  output logic                           m_psel_out,     // dev apb select
  output logic                           m_penable_out,  // dev apb enable
  output logic                           m_pwrite_out,   // dev apb direction
  output logic [ssd_host_pkg::DEV_AW-1:0] m_paddr_out,   // dev apb address
  output logic      [31:0]               m_pwdata_out,   // dev apb write data
  input  wire logic [31:0]               m_prdata_in,    // dev apb read data
  input  wire logic                      m_pready_in     // dev apb ready
);
  import ssd_host_pkg::*;

  typedef enum logic [4:0] {
    ST_LINK, ST_INIT, ST_IDLE, ST_SQE, ST_PATT, ST_CMD, ST_SPACE, ST_ADR_L,
    ST_ADR_H, ST_NEXT, ST_RWSTAT, ST_CNT_L, ST_CNT_H, ST_WAIT, ST_ERRT,
    ST_CAP_L, ST_CAP_H, ST_SLOW, ST_HALT
  } state_e;

  state_e               state_q;
  logic                 issued_q;
  logic                 done_q;
  logic [31:0]          rdata_q;
  logic                 req_valid;
  logic                 req_write;
  logic [DEV_AW-1:0]    req_addr;
  logic [31:0]          req_wdata;
  logic [2:0]           cmd_q;
  logic                 random_q;
  logic [31:0]          patt_q;
  logic [LBA_W-1:0]     start_q;
  logic [31:0]          len_q;
  logic [31:0]          poly_q;
  logic                 ready_q;
  logic                 err_q;
  logic                 verify_q;
  logic                 slow_q;
  logic                 dead_q;
  logic                 reject_q;
  logic [31:0]          err_type_q;
  logic [14:0]          link_q;
  logic [31:0]          cap_l_q;
  logic [31:0]          cap_h_q;
  logic [31:0]          cnt_l_q;
  logic [31:0]          cnt_h_q;
  logic [LBA_W-1:0]     adr_q;
  logic [31:0]          lfsr_q;
  logic [31:0]          remain_q;
  logic [31:0]          burst_q;
  logic [SQE_IDX_W-1:0] sqe_idx_q;
  logic [SQE_IDX_W-1:0] sqe_idx_d;
  logic                 s_wr;
  logic                 launch;
  logic                 is_rw;
  logic                 aligned;
  logic [31:0]          lfsr_step;
  logic [LBA_W-1:0]     lfsr_lba;
  logic [LBA_W-1:0]     cap_lba;
  logic [31:0]          space_ext;

  sqe_if sqe ();

  ssd_sqe_mem #(.WORDS(SQE_WORDS)) u_sqe_mem (
    .clk_sys_in (clk_sys_in),
    .port_in    (sqe)
  );

  // ==========
  // own register slave
  assign s_wr   = s_psel_in & s_penable_in & s_pwrite_in & s_pready_out;
  assign is_rw  = s_pwdata_in[2:1] == CMD_WRITE[2:1];
  assign launch = s_wr && (s_paddr_in == REG_CTRL) && (state_q == ST_IDLE) && !dead_q;
  assign aligned = ((start_q[2:0] | len_q[2:0]) & ALIGN_MASK) == 3'h0;

  assign sqe.wr_en   = s_wr && (s_paddr_in[7:6] == REG_SQE_BASE[7:6]);
  assign sqe.wr_idx  = s_paddr_in[5:2];
  assign sqe.wr_data = s_pwdata_in;
  assign sqe.rd_idx  = sqe_idx_d;

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      s_pready_out  <= 1'b0;
      s_pslverr_out <= 1'b0;
      s_prdata_out  <= 32'h0;
    end else begin
      s_pready_out  <= s_psel_in & ~s_penable_in;
      s_pslverr_out <= 1'b0;
      s_prdata_out  <= 32'h0;
      if (s_psel_in && !s_penable_in) begin
        case (s_paddr_in)
          REG_CTRL:    s_prdata_out <= {28'h0, random_q, cmd_q};
          REG_PATT:    s_prdata_out <= patt_q;
          REG_START_L: s_prdata_out <= start_q[31:0];
          REG_START_H: s_prdata_out <= {16'h0, start_q[47:32]};
          REG_LEN:     s_prdata_out <= len_q;
          REG_POLY:    s_prdata_out <= poly_q;
          REG_STATUS:  s_prdata_out <= {25'h0, reject_q, dead_q, slow_q, verify_q, err_q,
                                        ready_q, state_q != ST_IDLE};
          REG_ERRTYPE: s_prdata_out <= err_type_q;
          REG_LINK:    s_prdata_out <= {15'h0, link_q, 2'h0};
          REG_CAP_L:   s_prdata_out <= cap_l_q;
          REG_CAP_H:   s_prdata_out <= cap_h_q;
          REG_CNT_L:   s_prdata_out <= cnt_l_q;
          REG_CNT_H:   s_prdata_out <= cnt_h_q;
          default:     s_pslverr_out <= (s_paddr_in[7:6] != REG_SQE_BASE[7:6])
                                        || (s_paddr_in[1:0] != 2'h0);
        endcase
      end
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      cmd_q    <= CMD_IDENTIFY;
      random_q <= 1'b0;
      patt_q   <= 32'h0;
      start_q  <= '0;
      len_q    <= 32'h0;
      poly_q   <= POLY_RESET;
    end else if (s_wr && state_q == ST_IDLE) begin
      case (s_paddr_in)
        REG_CTRL: begin
          cmd_q    <= s_pwdata_in[2:0];
          random_q <= s_pwdata_in[3];
        end
        REG_PATT:    patt_q          <= s_pwdata_in;
        REG_START_L: start_q[31:0]   <= s_pwdata_in;
        REG_START_H: start_q[47:32]  <= s_pwdata_in[15:0];
        REG_LEN:     len_q           <= s_pwdata_in;
        REG_POLY:    poly_q          <= s_pwdata_in;
        default: begin
        end
      endcase
    end
  end

  // ==========
  // device access request decode
  always_comb begin
    req_valid = 1'b1;
    req_write = 1'b0;
    req_addr  = DEV_USR_STS;
    req_wdata = 32'h0;
    case (state_q)
      ST_LINK:  req_addr = DEV_LINK_STS;
      ST_SQE: begin
        req_write = 1'b1;
        req_addr  = DEV_SQE_BASE + {10'h0, sqe_idx_q, 2'h0};
        req_wdata = sqe.rd_data;
      end
      ST_PATT: begin
        req_write = 1'b1;
        req_addr  = DEV_PATT_SEL;
        req_wdata = patt_q;
      end
      ST_CMD: begin
        req_write = 1'b1;
        req_addr  = DEV_USR_CMD;
        req_wdata = {29'h0, cmd_q};
      end
      ST_SPACE: req_addr = DEV_FIFO_SPACE;
      ST_ADR_L: begin
        req_write = 1'b1;
        req_addr  = DEV_ADR_L;
        req_wdata = adr_q[31:0];
      end
      ST_ADR_H: begin
        req_write = 1'b1;
        req_addr  = DEV_ADR_H;
        req_wdata = {16'h0, adr_q[47:32]};
      end
      ST_CNT_L: req_addr = DEV_CNT_L;
      ST_CNT_H: req_addr = DEV_CNT_H;
      ST_ERRT:  req_addr = DEV_ERR_TYPE;
      ST_CAP_L: req_addr = DEV_CAP_L;
      ST_CAP_H: req_addr = DEV_CAP_H;
      ST_SLOW:  req_addr = DEV_SLOW_FLAG;
      ST_INIT, ST_WAIT, ST_RWSTAT: req_addr = DEV_USR_STS;
      default:  req_valid = 1'b0;
    endcase
  end

  // ==========
  // apb master engine
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      m_psel_out    <= 1'b0;
      m_penable_out <= 1'b0;
      m_pwrite_out  <= 1'b0;
      m_paddr_out   <= '0;
      m_pwdata_out  <= 32'h0;
      issued_q      <= 1'b0;
      done_q        <= 1'b0;
      rdata_q       <= 32'h0;
    end else begin
      done_q <= 1'b0;
      if (req_valid && !issued_q) begin
        m_psel_out   <= 1'b1;
        m_pwrite_out <= req_write;
        m_paddr_out  <= req_addr;
        m_pwdata_out <= req_wdata;
        issued_q     <= 1'b1;
      end else if (m_psel_out && !m_penable_out) begin
        m_penable_out <= 1'b1;
      end else if (m_psel_out && m_pready_in) begin
        m_psel_out    <= 1'b0;
        m_penable_out <= 1'b0;
        done_q        <= 1'b1;
        rdata_q       <= m_prdata_in;
      end else if (done_q) begin
        issued_q <= 1'b0;
      end
    end
  end

  // ==========
  // sequencer
  // lfsr step
  assign lfsr_step = lfsr_q[0] ? ((lfsr_q >> 1) ^ poly_q) : (lfsr_q >> 1);
  assign lfsr_lba  = {13'h0, lfsr_step, 3'h0};
  assign cap_lba   = {cap_h_q[15:0], cap_l_q};
  assign space_ext = {22'h0, rdata_q[9:0]};

  always_comb begin
    sqe_idx_d = sqe_idx_q;
    if (launch) begin
      sqe_idx_d = '0;
    end else if (state_q == ST_SQE && done_q) begin
      sqe_idx_d = sqe_idx_q + 4'h1;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      sqe_idx_q <= '0;
    end else begin
      sqe_idx_q <= sqe_idx_d;
    end
  end

  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      state_q <= ST_LINK;
    end else begin
      case (state_q)
        ST_LINK: if (done_q && rdata_q[LINK_UP]) state_q <= ST_INIT;
        ST_INIT: if (done_q) begin
          if (rdata_q[STS_ERR]) state_q <= ST_ERRT;
          else if (!rdata_q[STS_BUSY]) state_q <= ST_IDLE;
        end
        ST_IDLE: if (launch) begin
          if (is_rw && aligned) state_q <= ST_PATT;
          else if (is_rw) state_q <= ST_IDLE;
          else if (s_pwdata_in[2] && !s_pwdata_in[0])
            state_q <= ST_SQE;
          else state_q <= ST_CMD;
        end
        ST_SQE:  if (done_q && sqe_idx_q == 4'hf) state_q <= ST_CMD;
        ST_PATT: if (done_q) state_q <= ST_CMD;
        ST_CMD: if (done_q) begin
          if (cmd_q[2:1] == CMD_WRITE[2:1]) state_q <= ST_SPACE;
          else state_q <= ST_WAIT;
        end
        ST_SPACE: if (done_q) begin
          state_q <= (space_ext == 32'h0) ? ST_RWSTAT : ST_ADR_L;
        end
        ST_ADR_L: if (done_q) state_q <= ST_ADR_H;
        ST_ADR_H: if (done_q) state_q <= ST_NEXT;
        ST_NEXT: begin
          if (remain_q == 32'h0) state_q <= ST_RWSTAT;
          else if (!random_q || cap_lba == '0 || lfsr_lba <= cap_lba)
            state_q <= (burst_q == 32'h0) ? ST_RWSTAT : ST_ADR_L;
        end
        ST_RWSTAT: if (done_q) state_q <= rdata_q[STS_ERR] ? ST_ERRT : ST_CNT_L;
        ST_CNT_L: if (done_q) state_q <= ST_CNT_H;
        ST_CNT_H: if (done_q) state_q <= (remain_q == 32'h0) ? ST_WAIT : ST_SPACE;
        ST_WAIT: if (done_q) begin
          if (rdata_q[STS_ERR]) state_q <= ST_ERRT;
          else if (!rdata_q[STS_BUSY]) begin
            case (cmd_q)
              CMD_IDENTIFY: state_q <= ST_CAP_L;
              CMD_WRITE, CMD_READ: state_q <= ST_SLOW;
              CMD_SHUTDOWN: state_q <= ST_HALT;
              default: state_q <= ST_IDLE;
            endcase
          end
        end
        ST_ERRT:  if (done_q) state_q <= ST_HALT;
        ST_CAP_L: if (done_q) state_q <= ST_CAP_H;
        ST_CAP_H: if (done_q) state_q <= ST_IDLE;
        ST_SLOW:  if (done_q) state_q <= ST_IDLE;
        ST_HALT:  state_q <= ST_HALT;
        default:  state_q <= ST_HALT;
      endcase
    end
  end

  // address generation and burst accounting
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      adr_q    <= '0;
      lfsr_q   <= 32'h0;
      remain_q <= 32'h0;
      burst_q  <= 32'h0;
    end else begin
      if (launch) begin
        adr_q    <= start_q;
        lfsr_q   <= start_q[34:3];
        remain_q <= {3'h0, len_q[31:3]};
      end
      if (state_q == ST_SPACE && done_q) begin
        burst_q <= (space_ext < remain_q) ? space_ext : remain_q;
      end
      if (state_q == ST_ADR_H && done_q) begin
        remain_q <= remain_q - 32'h1;
        burst_q  <= burst_q - 32'h1;
      end
      if (state_q == ST_NEXT && remain_q != 32'h0) begin
        if (random_q) begin
          lfsr_q <= lfsr_step;
          adr_q  <= lfsr_lba;
        end else begin
          adr_q <= adr_q + BLOCK_SECTORS;
        end
      end
    end
  end

  // status flags and captured device values
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      ready_q    <= 1'b0;
      err_q      <= 1'b0;
      verify_q   <= 1'b0;
      slow_q     <= 1'b0;
      dead_q     <= 1'b0;
      reject_q   <= 1'b0;
      err_type_q <= 32'h0;
      link_q     <= '0;
      cap_l_q    <= 32'h0;
      cap_h_q    <= 32'h0;
      cnt_l_q    <= 32'h0;
      cnt_h_q    <= 32'h0;
    end else begin
      if (launch) begin
        err_q    <= 1'b0;
        verify_q <= 1'b0;
        slow_q   <= 1'b0;
        reject_q <= is_rw && !aligned;
      end
      if (state_q == ST_LINK && done_q && rdata_q[LINK_UP]) link_q <= rdata_q[16:2];
      if (state_q == ST_INIT && done_q && !rdata_q[STS_BUSY] && !rdata_q[STS_ERR])
        ready_q <= 1'b1;
      if ((state_q == ST_RWSTAT || state_q == ST_WAIT) && done_q && rdata_q[STS_VERIFY])
        verify_q <= 1'b1;
      if (state_q == ST_ERRT && done_q) begin
        err_q      <= 1'b1;
        err_type_q <= rdata_q;
        ready_q    <= 1'b0;
      end
      if (state_q == ST_CAP_L && done_q) cap_l_q <= rdata_q;
      if (state_q == ST_CAP_H && done_q) cap_h_q <= rdata_q;
      if (state_q == ST_CNT_L && done_q) cnt_l_q <= rdata_q;
      if (state_q == ST_CNT_H && done_q) cnt_h_q <= rdata_q;
      if (state_q == ST_SLOW && done_q) slow_q <= rdata_q[0];
      if (state_q == ST_WAIT && done_q && !rdata_q[STS_BUSY] && !rdata_q[STS_ERR]
          && cmd_q == CMD_SHUTDOWN) begin
        dead_q  <= 1'b1;
        ready_q <= 1'b0;
      end
    end
  end
endmodule

// >>> ssd_cmd_host_assertions.sv
// assertions on the ssd command host ports
`timescale 1ns/100ps
module ssd_cmd_host_chk import ssd_host_pkg::*; (
  input wire logic        clk_sys_in,    // clock
  input wire logic        rst_n_in,      // reset
  input wire logic        s_psel_in,     // own select
  input wire logic        s_penable_in,  // own enable
  input wire logic        s_pready_out,  // own ready
  input wire logic        m_psel_out,    // dev select
  input wire logic        m_penable_out, // dev enable
  input wire logic        m_pwrite_out,  // dev write
  input wire logic [15:0] m_paddr_out,   // dev address
  input wire logic [31:0] m_pwdata_out,  // dev data
  input wire logic        m_pready_in    // dev ready
);
  logic       patt_q;
  logic       dead_q;
  logic [4:0] sqe_q;
  logic       wr;
  logic       cmd_wr;
  logic       cmd_set;
  assign wr = m_psel_out & m_penable_out & m_pready_in & m_pwrite_out;
  assign cmd_wr = wr & (m_paddr_out == DEV_USR_CMD);
  assign cmd_set = m_psel_out & ~m_penable_out & m_pwrite_out & (m_paddr_out == DEV_USR_CMD);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);
  sequence dev_access; !m_penable_out ##1 m_penable_out; endsequence
  sequence dev_idle; !m_psel_out ##1 !m_psel_out; endsequence
  // ==========
  // helper state
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in || cmd_wr) begin
      patt_q <= 1'b0;
    end else if (wr && m_paddr_out == DEV_PATT_SEL) begin
      patt_q <= 1'b1;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in || cmd_wr) begin
      sqe_q <= 5'h0;
    end else if (wr && m_paddr_out[15:6] == 10'h008 && sqe_q != 5'h10) begin
      sqe_q <= sqe_q + 5'h1;
    end
  end
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      dead_q <= 1'b0;
    end else if (cmd_wr && m_pwdata_out[2:0] == CMD_SHUTDOWN) begin
      dead_q <= 1'b1;
    end
  end
  // ==========
  // properties
  AST_OWN_WAIT: assert property (s_psel_in && !s_penable_in |=> s_pready_out)
    else $error("own ready late");
  AST_DEV_SETUP: assert property ($rose(m_psel_out) |-> dev_access)
    else $error("device setup phase wrong");
  AST_DEV_HOLD: assert property (m_penable_out && !m_pready_in
    |=> m_penable_out && $stable(m_paddr_out) && $stable(m_pwdata_out))
    else $error("device request moved");
  AST_DEV_GAP: assert property (m_penable_out && m_pready_in |=> dev_idle)
    else $error("device gap missing");
  AST_LINK_FIRST: assert property ($rose(rst_n_in) |-> ##[1:3] m_psel_out &&
    m_paddr_out == DEV_LINK_STS) else $error("first access not link status");
  AST_PATT_FIRST: assert property (cmd_set && m_pwdata_out[2:1] == 2'b01 |-> patt_q)
    else $error("pattern not set before command");
  AST_SQE_FIRST: assert property (cmd_set && m_pwdata_out[2] && !m_pwdata_out[0]
    |-> sqe_q == 5'h10) else $error("entry not loaded");
  AST_NO_CMD_DEAD: assert property (cmd_set |-> !dead_q)
    else $error("command after shutdown");
endmodule
bind ssd_cmd_host ssd_cmd_host_chk ssd_cmd_host_chk_i (.*);

// >>> ssd_dev_model.sv
// behavioural model of the ssd test command register port
`timescale 1ns/100ps
module ssd_dev_model import ssd_host_pkg::*; #(
  parameter logic [31:0] LINK_V = 32'h0001234d,
  parameter logic [31:0] ERR_V  = 32'h00000010,
  parameter logic [63:0] CAP_V  = 64'h00000007fffffff8
) (
  input  wire logic        clk_sys_in, // clock
  input  wire logic        rst_n_in,   // reset
  input  wire logic        psel_in,    // select
  input  wire logic        penable_in, // enable
  input  wire logic        pwrite_in,  // write
  input  wire logic [15:0] paddr_in,   // address
  input  wire logic [31:0] pwdata_in,  // write data
  output logic      [31:0] prdata_out, // read data
  output logic             pready_out, // ready
  input  wire logic        stall_in,   // answer slowly
  input  wire logic        err_in,     // flag an error
  input  wire logic        vfy_in      // flag a mismatch
);
  logic [31:0] rd, last_q, adr_l_q, patt_q, slow_q;
  logic [31:0] sqe_q [16];
  logic [47:0] adr_q [$];
  logic [2:0]  cmd_q;
  int          busy_q, links_q, wait_q, ncmd;
  assign pready_out = psel_in & penable_in & (wait_q == 0);
  // ==========
  // read side
  always_comb begin
    case (paddr_in)
      DEV_LINK_STS: rd = (links_q > 2) ? LINK_V : 32'h0;
      DEV_USR_STS: rd = {29'h0, vfy_in, err_in, busy_q != 0};
      DEV_ERR_TYPE: rd = ERR_V;
      DEV_FIFO_SPACE: rd = 32'h3;
      DEV_SLOW_FLAG: rd = slow_q;
      DEV_CAP_L: rd = CAP_V[31:0];
      DEV_CAP_H: rd = CAP_V[63:32];
      DEV_CNT_L: rd = 32'(adr_q.size());
      default: rd = 32'h0;
    endcase
    prdata_out = pready_out ? rd : ~last_q;
  end
  // ==========
  // write side
  always_ff @(posedge clk_sys_in) begin
    if (!rst_n_in) begin
      busy_q <= 3;
      links_q <= 0;
      wait_q <= 0;
      slow_q <= 32'h0;
      last_q <= 32'h0;
      ncmd <= 0;
    end else begin
      if (psel_in && !penable_in) begin
        wait_q <= stall_in ? 3 : 0;
      end else if (wait_q != 0) begin
        wait_q <= wait_q - 1;
      end
      if (pready_out) begin
        last_q <= prdata_out;
        if (!pwrite_in && paddr_in == DEV_LINK_STS) links_q <= links_q + 1;
        if (!pwrite_in && paddr_in == DEV_USR_STS && busy_q != 0) busy_q <= busy_q - 1;
        if (pwrite_in && paddr_in == DEV_PATT_SEL) patt_q <= pwdata_in;
        if (pwrite_in && paddr_in == DEV_ADR_L) adr_l_q <= pwdata_in;
        if (pwrite_in && paddr_in == DEV_ADR_H) begin
          adr_q.push_back({pwdata_in[15:0], adr_l_q});
          slow_q <= 32'h1;
        end
        if (pwrite_in && paddr_in[15:6] == 10'h008) sqe_q[paddr_in[5:2]] <= pwdata_in;
        if (pwrite_in && paddr_in == DEV_USR_CMD && busy_q == 0) begin
          cmd_q <= pwdata_in[2:0];
          ncmd <= ncmd + 1;
          busy_q <= 4;
          slow_q <= 32'h0;
          if (pwdata_in[2:1] == 2'b01) adr_q.delete();
        end
      end
    end
  end
endmodule

// >>> tb.sv
// self-checking bench for the ssd command host
`timescale 1ns/100ps
module tb;
  import ssd_host_pkg::*;
  logic        clk_sys_in, rst_n_in, s_psel_in, s_penable_in, s_pwrite_in;
  logic [7:0]  s_paddr_in;
  logic [31:0] s_pwdata_in, s_prdata_out, m_pwdata_out, m_prdata_in, q;
  logic        s_pready_out, s_pslverr_out, m_psel_out, m_penable_out, m_pwrite_out;
  logic        m_pready_in, stall, err, vfy, serr;
  logic [15:0] m_paddr_out;
  int          err_total, checks, n0;
  ssd_cmd_host ssd_cmd_host_i (.*);
  ssd_dev_model ssd_dev_model_i (.clk_sys_in, .rst_n_in,
    .psel_in(m_psel_out), .penable_in(m_penable_out), .pwrite_in(m_pwrite_out),
    .paddr_in(m_paddr_out), .pwdata_in(m_pwdata_out), .prdata_out(m_prdata_in),
    .pready_out(m_pready_in), .stall_in(stall), .err_in(err), .vfy_in(vfy));
  // ==========
  // shared tasks
  task automatic summarize();
    $display("errors %0d checks %0d", err_total, checks);
    if (err_total == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, s);
    checks++;
    if (s !== e) begin
      err_total++;
      $display("ERROR %s exp %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic [7:0] a, input logic [31:0] d = 32'h0, input logic w = 1'b1);
    @(posedge clk_sys_in);
    s_psel_in <= 1'b1;
    s_pwrite_in <= w;
    s_paddr_in <= a;
    s_pwdata_in <= d;
    @(posedge clk_sys_in);
    s_penable_in <= 1'b1;
    for (int i = 0; i < 20 && s_pready_out !== 1'b1; i++) @(posedge clk_sys_in);
    if (s_pready_out !== 1'b1) begin
      chk("pready", 1, 0);
      summarize();
    end
    q = s_prdata_out;
    serr = s_pslverr_out;
    s_psel_in <= 1'b0;
    s_penable_in <= 1'b0;
  endtask
  task automatic wt(input int b, input logic v);
    for (int i = 0; i < 300; i++) begin
      apb(REG_STATUS, 0, 0);
      if (q[b] === v) return;
    end
    chk("timeout", 0, 1);
    summarize();
  endtask
  // ==========
  // scenarios
  task automatic t_boot();
    wt(ST_BIT_BUSY, 1'b0);
    chk("ready", 1, q[ST_BIT_READY]);
    apb(REG_LINK, 0, 0);
    chk("link", 32'h0001234d >> 2, q[16:2]);
  endtask
  task automatic t_ident();
    apb(REG_CTRL, 32'(CMD_IDENTIFY));
    apb(REG_STATUS, 0, 0);
    chk("busy", 1, q[ST_BIT_BUSY]);
    wt(ST_BIT_BUSY, 1'b0);
    chk("cmd", CMD_IDENTIFY, ssd_dev_model_i.cmd_q);
    apb(REG_CAP_L, 0, 0);
    chk("cap_l", 32'hfffffff8, q);
    apb(REG_CAP_H, 0, 0);
    chk("cap_h", 32'h7, q);
  endtask
  task automatic t_rw(input logic [2:0] c, input logic r);
    logic [47:0] a;
    n0 = ssd_dev_model_i.ncmd;
    stall <= 1'b1;
    apb(REG_PATT, 32'h5);
    apb(REG_START_L, 32'h10);
    apb(REG_START_H, 32'h0);
    apb(REG_LEN, 32'h28);
    apb(REG_CTRL, {28'h0, r, c});
    apb(REG_CTRL, 32'(CMD_SMART));
    wt(ST_BIT_BUSY, 1'b0);
    stall <= 1'b0;
    chk("ncmd", n0 + 1, ssd_dev_model_i.ncmd);
    chk("cmd", c, ssd_dev_model_i.cmd_q);
    chk("patt", 32'h5, ssd_dev_model_i.patt_q);
    chk("slow", 1, q[ST_BIT_SLOW]);
    chk("verify", vfy, q[ST_BIT_VERIFY]);
    apb(REG_CNT_L, 0, 0);
    chk("count", 32'h5, q);
    for (int i = 0; i < 5; i++) begin
      a = ssd_dev_model_i.adr_q[i];
      if (!r || i == 0) chk("addr", 16 + 8 * i, a[31:0]);
      else chk("align", 0, a[2:0]);
    end
  endtask
  task automatic t_rej();
    n0 = ssd_dev_model_i.ncmd;
    apb(REG_LEN, 32'hc);
    apb(REG_CTRL, 32'(CMD_WRITE));
    wt(ST_BIT_BUSY, 1'b0);
    chk("reject", 1, q[ST_BIT_REJECT]);
    chk("ncmd", n0, ssd_dev_model_i.ncmd);
    apb(8'h34, 0, 0);
    chk("slverr", 1, serr);
  endtask
  task automatic t_sqe(input logic [2:0] c);
    for (int i = 0; i < 16; i++) apb(REG_SQE_BASE + 8'(4 * i), 32'(i + 16 * c));
    apb(REG_CTRL, 32'(c));
    wt(ST_BIT_BUSY, 1'b0);
    chk("cmd", c, ssd_dev_model_i.cmd_q);
    for (int i = 0; i < 16; i++) chk("sqe", i + 16 * c, ssd_dev_model_i.sqe_q[i]);
  endtask
  task automatic t_err();
    err <= 1'b1;
    apb(REG_CTRL, 32'(CMD_FLUSH));
    wt(ST_BIT_ERR, 1'b1);
    err <= 1'b0;
    apb(REG_ERRTYPE, 0, 0);
    chk("errtype", 32'h10, q);
    apb(REG_STATUS, 0, 0);
    chk("sticky", 1, q[ST_BIT_ERR]);
  endtask
  task automatic t_shut();
    apb(REG_CTRL, 32'(CMD_SHUTDOWN));
    wt(ST_BIT_DEAD, 1'b1);
    n0 = ssd_dev_model_i.ncmd;
    apb(REG_CTRL, 32'(CMD_IDENTIFY));
    repeat (20) @(posedge clk_sys_in);
    chk("dead", n0, ssd_dev_model_i.ncmd);
  endtask
  // ==========
  // main sequence
  initial begin
    clk_sys_in = 1'b0;
    forever #10 clk_sys_in = ~clk_sys_in;
  end
  initial begin
    {rst_n_in, s_psel_in, s_penable_in, s_pwrite_in, stall, err, vfy} = 7'h0;
    {s_paddr_in, s_pwdata_in, err_total, checks} = '0;
    repeat (5) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    t_boot();
    t_ident();
    t_rw(CMD_WRITE, 1'b0);
    vfy <= 1'b1;
    t_rw(CMD_READ, 1'b1);
    vfy <= 1'b0;
    t_rej();
    t_sqe(CMD_SMART);
    t_sqe(CMD_FLUSH);
    t_err();
    rst_n_in <= 1'b0;
    repeat (5) @(posedge clk_sys_in);
    rst_n_in <= 1'b1;
    t_boot();
    t_shut();
    summarize();
  end
endmodule
